// File: verilog/flash_status_pkg.sv
// shared constants for the flash status and read configuration block
// assumes one 100 MHz clock and a host that sends commands on that clock
package flash_status_pkg;

  // status register bit positions
  localparam int SR_CONTROLLER_IDLE   = 7;
  localparam int SR_ERASE_PAUSED      = 6;
  localparam int SR_ERASE_FAIL        = 5;
  localparam int SR_PROGRAM_FAIL      = 4;
  localparam int SR_SUPPLY_INVALID    = 3;
  localparam int SR_PROGRAM_PAUSED    = 2;
  localparam int SR_LOCKED_BLOCK      = 1;
  localparam int SR_BANK_OR_WORD      = 0;
  localparam logic [7:0] STATUS_RESET = 8'h80;

  // configuration register field positions
  localparam int CR_READ_SELECT       = 15;
  localparam int CR_LATENCY_HI        = 13;
  localparam int CR_LATENCY_LO        = 11;
  localparam int CR_WAIT_POLARITY     = 10;
  localparam int CR_OUTPUT_HOLD       = 9;
  localparam logic [15:0] CFG_RESET      = 16'hbfcf;
  localparam logic [15:0] CFG_WRITE_MASK = 16'hbfcf;

  // command operations on the command interface
  localparam logic [1:0] OP_SET_CONFIG   = 2'h1;
  localparam logic [1:0] OP_CLEAR_STATUS = 2'h2;

  // bank number width
  localparam int BANK_W = 4;

  // read sequencer states
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_ASYNC,
    RD_LATENCY,
    RD_DATA
  } read_state_t;

endpackage

// File: verilog/flash_status_and_read_config.sv
// status register and read configuration logic of a multi-bank burst flash
// assumes controller inputs and commands are on i_clock; the burst clock is a pin
//
// the block owns the two registers that the host sees: the status word that it
// polls while a program or erase runs, and the read configuration that decides
// how later reads present their data
// the program/erase controller, the array and the address path stay outside;
// they report their state here through level and pulse inputs
// things a user of this block must know:
// - the burst clock is sampled by i_clock, so it must stay well below half the
//   100 MHz rate; each of its rising edges is seen about three cycles late
// - the status word follows the controller inputs one cycle late, never at once
// - a set-configuration command never disturbs a read that is already running
// - reserved configuration bits always read back as zero
// - error flags are only ever cleared by the clear-status command or by reset;
//   an error event in the same cycle as the clear keeps its flag set
// - the wait output is deasserted outside bursts, at the level of the
//   polarity that the last read took
`timescale 1ns/1ns

module flash_status_and_read_config
  import flash_status_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  // command interface
  input  wire logic              i_cmd_strobe,
  input  wire logic [1:0]        i_cmd_op,
  input  wire logic [15:0]       i_cmd_data,
  // program/erase controller state
  input  wire logic              i_pe_busy,
  input  wire logic              i_erase_suspended,
  input  wire logic              i_program_suspended,
  input  wire logic              i_erase_fail_event,
  input  wire logic              i_program_fail_event,
  input  wire logic              i_supply_invalid_event,
  input  wire logic              i_locked_block_event,
  input  wire logic [BANK_W-1:0] i_busy_bank,
  input  wire logic [BANK_W-1:0] i_addressed_bank,
  input  wire logic              i_fast_factory_program_mode,
  input  wire logic              i_ffp_word_busy,
  // read path
  input  wire logic              i_burst_clock,
  input  wire logic              i_read_start,
  input  wire logic              i_read_end,
  input  wire logic [15:0]       i_array_data,
  output logic [7:0]             o_status,
  output logic [15:0]            o_config,
  output logic                   o_abort,
  output logic                   o_sync_mode,
  output logic [15:0]            o_read_data,
  output logic                   o_data_valid,
  output logic                   o_word_advance,
  output logic                   o_wait
);

  // all state of the block
  typedef struct packed {
    // burst clock synchroniser and edge history
    logic        k_meta;
    logic        k_sync;
    logic        k_prev;
    // configuration register and its decoded read mode
    logic [15:0] cfg;
    logic        sync_mode;
    // sticky error flags
    logic        erase_fail;
    logic        program_fail;
    logic        supply_invalid;
    logic        locked_block;
    // registered status word and abort pulse
    logic [7:0]  status;
    logic        abort;
    // read sequencer and the configuration taken at its start
    read_state_t rd_state;
    logic [2:0]  rd_latency;
    logic        rd_hold_two;
    logic        rd_polarity;
    logic [2:0]  edge_cnt;
    logic        hold_cnt;
    // read outputs
    logic [15:0] read_data;
    logic        data_valid;
    logic        word_advance;
    logic        wait_pin;
  } state_t;

  state_t state;
  state_t next_state;

  // helpers of the next-state logic, all given a value at the top of it;
  // k_rise is one cycle per synchronised burst clock rising edge, and
  // first_edge_done marks the edge on which the latency count is reached
  logic k_rise;
  logic wait_active;
  logic bank_flag;
  logic first_edge_done;

  // next state
  always_comb begin
    next_state = state;
    k_rise = state.k_sync & ~state.k_prev;
    wait_active = 1'b0;
    bank_flag = 1'b0;
    first_edge_done = 1'b0;

    // burst clock pin passes two flip-flops, then edge detect;
    // the history flop resets low like the idle pin, so no edge follows reset,
    // and only the second flop feeds the edge logic
    next_state.k_meta = i_burst_clock;
    next_state.k_sync = state.k_meta;
    next_state.k_prev = state.k_sync;

    // configuration only changes on the set-configuration command;
    // other op codes leave it alone, and the mask keeps reserved bits at zero
    if (i_cmd_strobe && (i_cmd_op == OP_SET_CONFIG)) begin
      next_state.cfg = i_cmd_data & CFG_WRITE_MASK;
    end

    // sticky error flags: clear first, so a same-cycle event wins;
    // losing an error that happened while the host cleared would hide a failed
    // operation, so the set side is given priority on purpose
    if (i_cmd_strobe && (i_cmd_op == OP_CLEAR_STATUS)) begin
      next_state.erase_fail = 1'b0;
      next_state.program_fail = 1'b0;
      next_state.supply_invalid = 1'b0;
      next_state.locked_block = 1'b0;
    end
    if (i_erase_fail_event) begin
      next_state.erase_fail = 1'b1;
    end
    if (i_program_fail_event) begin
      next_state.program_fail = 1'b1;
    end
    if (i_supply_invalid_event) begin
      next_state.supply_invalid = 1'b1;
    end
    if (i_locked_block_event) begin
      next_state.locked_block = 1'b1;
    end

    // abort request to the controller on a protected or unpowered target;
    // registered, so it rises one cycle after an event and stays high for as long as an event input stays high
    next_state.abort = i_locked_block_event | i_supply_invalid_event;

    // bank busy or word ready flag
    // an idle controller always shows 0, which also covers leaving fast
    // program mode; while busy the same bit carries either the word-ready
    // state of fast program mode or the other-bank indication
    if (!i_pe_busy) begin
      bank_flag = 1'b0;
    end else if (i_fast_factory_program_mode) begin
      bank_flag = i_ffp_word_busy;
    end else begin
      bank_flag = (i_busy_bank != i_addressed_bank);
    end

    // status word, registered so the output comes from a flip-flop;
    // error bits take the next flag values so a flag and its bit move together
    next_state.status[SR_CONTROLLER_IDLE] = ~i_pe_busy;
    next_state.status[SR_ERASE_PAUSED] = i_erase_suspended;
    next_state.status[SR_ERASE_FAIL] = next_state.erase_fail;
    next_state.status[SR_PROGRAM_FAIL] = next_state.program_fail;
    next_state.status[SR_SUPPLY_INVALID] = next_state.supply_invalid;
    next_state.status[SR_PROGRAM_PAUSED] = i_program_suspended;
    next_state.status[SR_LOCKED_BLOCK] = next_state.locked_block;
    next_state.status[SR_BANK_OR_WORD] = bank_flag;

    // read mode held in its own flop so the output needs no gate
    next_state.sync_mode = ~next_state.cfg[CR_READ_SELECT];

    // read sequencer
    // a start pulse always wins, even in the middle of a read, so the host can
    // restart at a new address; an end pulse returns to idle next cycle
    // the configuration fields are copied at the start so that a command given
    // during a burst cannot change its latency, hold time or wait polarity
    next_state.word_advance = 1'b0;
    if (i_read_start) begin
      // snapshot the configuration so a later command leaves this read alone
      next_state.rd_latency = state.cfg[CR_LATENCY_HI:CR_LATENCY_LO];
      next_state.rd_hold_two = state.cfg[CR_OUTPUT_HOLD];
      next_state.rd_polarity = state.cfg[CR_WAIT_POLARITY];
      next_state.edge_cnt = 3'h0;
      next_state.hold_cnt = 1'b0;
      if (state.cfg[CR_READ_SELECT]) begin
        // asynchronous: present the addressed word at once
        next_state.rd_state = RD_ASYNC;
        next_state.read_data = i_array_data;
        next_state.data_valid = 1'b1;
      end else begin
        // synchronous: bank and block boundaries do not stop the burst
        next_state.rd_state = RD_LATENCY;
        next_state.data_valid = 1'b0;
      end
    end else if (i_read_end) begin
      next_state.rd_state = RD_IDLE;
      next_state.data_valid = 1'b0;
    end else begin
      unique case (state.rd_state)
        RD_IDLE: begin
          next_state.data_valid = 1'b0;
        end
        RD_ASYNC: begin
          // asynchronous output follows the array word
          next_state.read_data = i_array_data;
        end
        RD_LATENCY: begin
          if (k_rise) begin
            // first data after the latency count of burst clock edges;
            // codes 0 and 1 behave as a latency of one edge, and the counter
            // never wraps because it stops one below the code it compares against
            first_edge_done = ((state.edge_cnt + 3'h1) >= state.rd_latency);
            if (first_edge_done) begin
              next_state.rd_state = RD_DATA;
              next_state.read_data = i_array_data;
              next_state.data_valid = 1'b1;
              next_state.word_advance = 1'b1;
              next_state.hold_cnt = 1'b0;
            end else begin
              next_state.edge_cnt = state.edge_cnt + 3'h1;
            end
          end
        end
        RD_DATA: begin
          if (k_rise) begin
            // each word stands one or two burst clocks
            if (!state.rd_hold_two || state.hold_cnt) begin
              next_state.read_data = i_array_data;
              next_state.word_advance = 1'b1;
              next_state.hold_cnt = 1'b0;
            end else begin
              next_state.hold_cnt = 1'b1;
            end
          end
        end
      endcase
    end

    // wait pin: asserted while a synchronous word is not yet valid
    // the asserted level is the snapshot polarity; on a start pulse the
    // snapshot is not yet in the flop, so the live bit is used for that cycle
    wait_active = (next_state.rd_state == RD_LATENCY);
    next_state.wait_pin = wait_active ~^ next_state.rd_polarity;
    if (i_read_start) begin
      next_state.wait_pin = wait_active ~^ state.cfg[CR_WAIT_POLARITY];
    end
  end

  // state register
  // reset gives the documented defaults: asynchronous reads, active high wait,
  // two-clock hold and the reserved latency code, with all error flags clear
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state <= '0;
      state.cfg <= CFG_RESET;
      state.status <= STATUS_RESET;
      state.rd_state <= RD_IDLE;
      state.rd_polarity <= 1'b1;
      state.rd_hold_two <= 1'b1;
      state.rd_latency <= 3'h7;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from the state register
  // no output passes through a gate, so each one settles right after the edge
  assign o_status = state.status;
  assign o_config = state.cfg;
  assign o_abort = state.abort;
  assign o_sync_mode = state.sync_mode;
  assign o_read_data = state.read_data;
  assign o_data_valid = state.data_valid;
  assign o_word_advance = state.word_advance;
  assign o_wait = state.wait_pin;

endmodule

// File: test/flash_status_monitor.sv
// checker for the status flags and the configuration register
// sees only top ports; attached by the bind after the module
`timescale 1ns/1ns
module flash_status_monitor
  import flash_status_pkg::*;
(
  input wire logic              i_clock, i_reset, i_cmd_strobe, i_pe_busy,
  input wire logic              i_erase_suspended, i_program_suspended, i_locked_block_event,
  input wire logic              i_fast_factory_program_mode, i_ffp_word_busy, o_abort,
  input wire logic [1:0]        i_cmd_op,
  input wire logic [15:0]       i_cmd_data, o_config,
  input wire logic [BANK_W-1:0] i_busy_bank, i_addressed_bank,
  input wire logic [7:0]        o_status
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // decoded commands
  wire logic set_cmd = i_cmd_strobe && i_cmd_op == OP_SET_CONFIG;
  wire logic clr_cmd = i_cmd_strobe && i_cmd_op == OP_CLEAR_STATUS;
  // status flags against controller state
  idle_flag_a: assert property (1 |=> o_status[7] == !$past(i_pe_busy))
    else $error("idle flag wrong");
  pause_flags_a: assert property (1 |=> o_status[6] == $past(i_erase_suspended)
    && o_status[2] == $past(i_program_suspended)) else $error("pause flag wrong");
  idle_bank_a: assert property (o_status[7] |-> !o_status[0])
    else $error("bank flag set while idle");
  bank_flag_a: assert property (i_pe_busy && !i_fast_factory_program_mode |=>
    o_status[0] == ($past(i_busy_bank) != $past(i_addressed_bank))) else $error("bank flag wrong");
  word_ready_a: assert property (i_pe_busy && i_fast_factory_program_mode |=>
    o_status[0] == $past(i_ffp_word_busy)) else $error("word flag wrong");
  // sticky errors and their clearing
  sticky_error_a: assert property (o_status[5] && !clr_cmd |=> o_status[5])
    else $error("error flag dropped");
  locked_abort_a: assert property (i_locked_block_event |=> o_status[1] && o_abort)
    else $error("locked flag or abort missing");
  clear_locked_a: assert property (clr_cmd && !i_locked_block_event |=> !o_status[1])
    else $error("clear ignored");
  // configuration written only by its command
  config_load_a: assert property (set_cmd |=> o_config == ($past(i_cmd_data) & CFG_WRITE_MASK))
    else $error("config load wrong");
  config_hold_a: assert property (!set_cmd |=> $stable(o_config))
    else $error("config changed");
  cover property (set_cmd);
  cover property (i_locked_block_event);
  cover property (i_pe_busy && i_fast_factory_program_mode);
endmodule
bind flash_status_and_read_config flash_status_monitor flash_status_monitor_i (
  .i_clock(i_clock), .i_reset(i_reset), .i_cmd_strobe(i_cmd_strobe), .i_pe_busy(i_pe_busy),
  .i_erase_suspended(i_erase_suspended), .i_program_suspended(i_program_suspended),
  .i_locked_block_event(i_locked_block_event), .i_fast_factory_program_mode(i_fast_factory_program_mode),
  .i_ffp_word_busy(i_ffp_word_busy), .o_abort(o_abort), .i_cmd_op(i_cmd_op), .i_cmd_data(i_cmd_data),
  .o_config(o_config), .i_busy_bank(i_busy_bank), .i_addressed_bank(i_addressed_bank), .o_status(o_status));

// File: test/host_burst_source.sv
// host side burst clock source for synchronous reads
// assumes the bench raises i_run for the length of a burst
`timescale 1ns/1ns
module host_burst_source (
  input  wire logic i_run,
  output logic      o_burst_clock
);
  // 160 ns period inside a burst, stands low between bursts
  initial o_burst_clock = 1'b0;
  always #80 o_burst_clock = i_run ? !o_burst_clock : 1'b0;
endmodule

// File: test/test_flash_status_and_read_config.sv
// bench for the flash status and read configuration block
// drives commands, controller state and reads; burst clock from the host model
`timescale 1ns/1ns
module test_flash_status_and_read_config;
  import flash_status_pkg::*;
  logic i_clock = 0, i_reset = 1, i_cmd_strobe = 0, i_pe_busy = 0, i_erase_suspended = 0;
  logic i_program_suspended = 0, i_erase_fail_event = 0, i_program_fail_event = 0, run = 0;
  logic i_supply_invalid_event = 0, i_locked_block_event = 0, i_fast_factory_program_mode = 0;
  logic i_ffp_word_busy = 0, i_burst_clock, i_read_start = 0, i_read_end = 0;
  logic o_abort, o_sync_mode, o_data_valid, o_word_advance, o_wait;
  logic [1:0] i_cmd_op = 0;
  logic [15:0] i_cmd_data = 0, i_array_data = 16'h1234, o_config, o_read_data;
  logic [BANK_W-1:0] i_busy_bank = 0, i_addressed_bank = 0;
  logic [7:0] o_status;
  int error_cnt = 0, checks = 0, edges = 0;
  always #5 i_clock = !i_clock;
  always @(posedge i_burst_clock) edges++;
  flash_status_and_read_config flash_status_and_read_config_i (.*);
  host_burst_source host_burst_source_i (.i_run(run), .o_burst_clock(i_burst_clock));
  // compare one value
  task automatic check(input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one command cycle, then look after it lands
  task automatic cmd(input logic [1:0] op, input logic [15:0] d);
    @(posedge i_clock);
    i_cmd_strobe <= 1;
    i_cmd_op <= op;
    i_cmd_data <= d;
    @(posedge i_clock);
    i_cmd_strobe <= 0;
    @(negedge i_clock);
  endtask
  // synchronous burst: wait level, latency in burst edges, first word
  task automatic burst(input int lat, input logic pol, input logic hold);
    int gap;
    @(posedge i_clock);
    edges = 0;
    i_read_start <= 1;
    run <= 1;
    @(posedge i_clock);
    i_read_start <= 0;
    @(posedge i_clock);
    @(negedge i_clock);
    check(o_wait, pol);
    check(o_sync_mode, 1);
    for (int n = 0; n < 200 && o_data_valid !== 1'b1; n++) @(negedge i_clock);
    check(o_data_valid, 1);
    if (o_data_valid !== 1'b1) give_verdict();
    check(edges, lat);
    check(o_wait, !pol);
    check(o_read_data, i_array_data);
    check(o_word_advance, 1);
    gap = 0;
    @(negedge i_clock);
    for (int n = 0; n < 100 && o_word_advance !== 1'b1; n++) begin
      gap++;
      @(negedge i_clock);
    end
    check(gap, hold ? 16'h1f : 16'hf);
    @(posedge i_clock);
    i_read_end <= 1;
    run <= 0;
    @(posedge i_clock);
    i_read_end <= 0;
  endtask
  initial begin
    repeat (10) @(posedge i_clock);
    i_reset <= 0;
    @(negedge i_clock);
    check(o_status, STATUS_RESET);
    check(o_config, CFG_RESET);
    // every busy / fast mode / word state, bank differing when word flag low
    for (int k = 0; k < 8; k++) begin
      @(posedge i_clock);
      {i_pe_busy, i_fast_factory_program_mode, i_ffp_word_busy} <= k[2:0];
      i_busy_bank <= k[0] ? 4'h5 : 4'h3;
      i_addressed_bank <= 4'h5;
      @(posedge i_clock);
      @(negedge i_clock);
      check({o_status[7], o_status[0]}, {!k[2], k[2] & (k[1] ? k[0] : !k[0])});
    end
    // suspend flags, ending with both low and the controller idle
    for (int j = 3; j >= 0; j--) begin
      @(posedge i_clock);
      {i_erase_suspended, i_program_suspended, i_pe_busy} <= {j[1:0], 1'b0};
      @(posedge i_clock);
      @(negedge i_clock);
      check({o_status[6], o_status[2]}, j[1:0]);
    end
    // all error events at once, then sticky, then cleared by the host
    @(posedge i_clock);
    {i_erase_fail_event, i_program_fail_event, i_supply_invalid_event, i_locked_block_event} <= 4'hf;
    @(posedge i_clock);
    {i_erase_fail_event, i_program_fail_event, i_supply_invalid_event, i_locked_block_event} <= 4'h0;
    @(negedge i_clock);
    check({o_abort, o_status}, 9'h1ba);
    repeat (5) @(negedge i_clock);
    check(o_status, 8'hba);
    cmd(OP_CLEAR_STATUS, 16'h0);
    check(o_status, STATUS_RESET);
    // asynchronous read under the reset configuration
    @(posedge i_clock);
    i_read_start <= 1;
    @(posedge i_clock);
    i_read_start <= 0;
    @(negedge i_clock);
    check({o_sync_mode, o_data_valid, o_wait}, 3'h2);
    check(o_read_data, i_array_data);
    @(posedge i_clock);
    i_read_end <= 1;
    @(posedge i_clock);
    i_read_end <= 0;
    // configuration through commands only, reserved bits kept zero
    cmd(OP_SET_CONFIG, 16'hffff);
    check(o_config, CFG_WRITE_MASK);
    cmd(2'h3, 16'h0);
    check(o_config, CFG_WRITE_MASK);
    // latency 2 active high one-clock hold, then latency 3 active low two-clock hold
    cmd(OP_SET_CONFIG, 16'h1400);
    burst(2, 1'b1, 1'b0);
    cmd(OP_SET_CONFIG, 16'h1a00);
    burst(3, 1'b0, 1'b1);
    give_verdict();
  end
endmodule
